// [rtl/tcp_defines.svh]
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets on the apb
// ----------------------------------------------------------------
`define TCP_OFF_CTRL 8'h00
`define TCP_OFF_STATUS 8'h04
`define TCP_OFF_PRELOAD 8'h08
`define TCP_OFF_COUNT 8'h0c
`define TCP_OFF_PC_DATA 8'h10
`define TCP_OFF_PC_DIR 8'h14
`define TCP_OFF_VECTOR 8'h18

// ----------------------------------------------------------------
// timer_control fields
// ----------------------------------------------------------------
`define TCP_BIT_ENABLE 0
`define TCP_BIT_CLK_LO 1
`define TCP_BIT_CLK_HI 2
`define TCP_BIT_UNUSED 3
`define TCP_BIT_ZDCTL 4
`define TCP_BIT_PIN_LO 5
`define TCP_BIT_PIN_HI 7
`define TCP_CTRL_MASK 8'hf7

// ----------------------------------------------------------------
// port c line positions
// ----------------------------------------------------------------
`define TCP_LINE_TIN 2
`define TCP_LINE_TIMER_OUTPUT_PIN 3
`define TCP_LINE_TIMER_ACKNOWLEDGE_PIN 7

// ----------------------------------------------------------------
// widths, reset values and constants
// ----------------------------------------------------------------
`define TCP_CNT_W 24
`define TCP_PSC_W 5
`define TCP_PSC_TOP 5'h1f
`define TCP_CTRL_RST 8'h00
`define TCP_DIR_RST 8'h00
`define TCP_VEC_RST 8'h0f
`define TCP_CNT_ONES 24'hffffff
`define TCP_CNT_ONE 24'h000001

`endif

// [rtl/tcp_pkg.sv]
`default_nettype none
`include "tcp_defines.svh"

package tcp_pkg;

  // timer run state, one-hot
  typedef enum logic [1:0] {
    TCP_HALT = 2'b01,
    TCP_RUN  = 2'b10
  } tcp_run_t;

  // pin function selected by timer_control bits 7..5
  typedef enum logic [2:0] {
    TCP_PIN_PORTC0 = 3'b000,
    TCP_PIN_PORTC1 = 3'b001,
    TCP_PIN_SQ0    = 3'b010,
    TCP_PIN_SQ1    = 3'b011,
    TCP_PIN_VEC_DIS = 3'b100,
    TCP_PIN_VEC_EN  = 3'b101,
    TCP_PIN_AUTO_DIS = 3'b110,
    TCP_PIN_AUTO_EN  = 3'b111
  } tcp_pin_mode_t;

  // clock path selected by timer_control bits 2..1
  typedef enum logic [1:0] {
    TCP_CLK_SYS   = 2'b00,
    TCP_CLK_GATED = 2'b01,
    TCP_CLK_TIN_PSC = 2'b10,
    TCP_CLK_TIN   = 2'b11
  } tcp_clk_mode_t;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } tcp_apb_req_t;

  // port c pad drive
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } tcp_pins_t;

  // reset state of the block
  typedef struct packed {
    logic [7:0] ctrl;
    logic zero_detect_flag;
    logic [`TCP_PSC_W-1:0] psc;
    logic first;
    tcp_run_t run;
    logic timer_output_pin_sq;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic [7:0] pin_f;
    logic tin_prev;
    logic [7:0] pc_dir;
    logic [7:0] vector;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    tcp_pins_t pins;
    logic ack_valid;
    logic [7:0] ack_vector;
  } tcp_state_t;

  // state that reset leaves alone
  typedef struct packed {
    logic [`TCP_CNT_W-1:0] cnt;
    logic [`TCP_CNT_W-1:0] preload;
    logic [7:0] pc_data;
  } tcp_keep_t;

endpackage
`default_nettype wire

// [rtl/tcp_timer.sv]
// How it works
// - pin mode 00x: timer output and acknowledge lines are plain port c lines
// - pin mode 01x: output toggles on zero detect, high when halted, line 7 port c
// - mode 100: request line three-stated, no data or ack on acknowledge
// - mode 101: request line low while flag set, line 7 is acknowledge input
// - mode 110: request line always three-stated, line 7 port c
// - mode 111: request line low while flag set, line 7 port c, no vector
// - zero-detect bit clear: reload from preload on first counter clock after zero
// - zero-detect bit set: counter wraps past zero without reload
// - control bit 3 reads zero
// - clock 00: prescaler steps every clock, counter steps on prescaler wrap
// - clock 01: run only while enabled and timer input high
// - clock 10: synchronised input rising edge steps prescaler, wrap steps counter
// - clock 11: synchronised input rising edge steps counter directly
// - control bit 0 enables the timer
// - control register always accessible, cleared by reset
// - port c read: pin level when direction 0, latch when direction 1
// - port c write always hits latch, driven only in port c use with direction 1
// - port c latch untouched by reset, access independent of mode
// - flag set on count 1 to 0, cleared by writing one or by halt
// - halted: count held, prescaler all ones, flag zero
// - preload enters counter at first counter clock after entering run
`timescale 1ns/1ns
`default_nettype none
`include "tcp_defines.svh"

module tcp_timer #(
  parameter int CNT_W = `TCP_CNT_W,
  parameter int PSC_W = `TCP_PSC_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // port c pads
  input wire logic [7:0] i_pc_pin,
  output logic [7:0] o_pc_out,
  output logic [7:0] o_pc_oe_n,
  // timer acknowledge answer
  output logic o_ack_valid,
  output logic [7:0] o_ack_vector
);
  import tcp_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (CNT_W != `TCP_CNT_W || PSC_W != `TCP_PSC_W) begin : g_bad_width
    $error("tcp_timer: widths must match the compiled state layout");
  end

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  tcp_state_t s;
  tcp_state_t next_s;
  tcp_keep_t k;
  tcp_keep_t next_k;
  tcp_apb_req_t req;
  tcp_pin_mode_t pin_mode;
  tcp_clk_mode_t clk_mode;
  logic run_now;
  logic external_timer_input;
  logic tin_rise;
  logic psc_step;
  logic tick;
  logic zds_set;
  logic zds_clr;
  logic setup;
  logic wr_done;

  // port c read view, shared by the read mux
  function automatic logic [7:0] pc_view(input logic [7:0] pin, input logic [7:0] latch,
                                         input logic [7:0] dir);
    pc_view = (pin & ~dir) | (latch & dir);
  endfunction

  // write one byte lane into an old value
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] wd,
                                      input logic strb);
    lane = strb ? wd : old;
  endfunction

  // bus request bundle
  assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite, paddr: i_paddr,
                 pwdata: i_pwdata, pstrb: i_pstrb};

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_k = k;
    pin_mode = tcp_pin_mode_t'(s.ctrl[`TCP_BIT_PIN_HI:`TCP_BIT_PIN_LO]);
    clk_mode = tcp_clk_mode_t'(s.ctrl[`TCP_BIT_CLK_HI:`TCP_BIT_CLK_LO]);
    setup = req.psel && !req.penable;
    wr_done = req.psel && req.penable && s.pready && req.pwrite;
    tick = 1'b0;
    psc_step = 1'b0;
    zds_set = 1'b0;
    zds_clr = 1'b0;

    // three-stage pad synchroniser, filtered once stages two and three agree
    next_s.sync1 = i_pc_pin;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    if (s.sync2 == s.sync3) begin
      next_s.pin_f = s.sync3;
    end
    external_timer_input = s.pin_f[`TCP_LINE_TIN];
    tin_rise = external_timer_input && !s.tin_prev;
    next_s.tin_prev = external_timer_input;

    // run or halt decision
    run_now = s.ctrl[`TCP_BIT_ENABLE] && (clk_mode != TCP_CLK_GATED || external_timer_input);

    // register writes at the access edge
    if (wr_done && !s.pslverr) begin
      case (req.paddr)
        `TCP_OFF_CTRL: begin
          next_s.ctrl = lane(s.ctrl, req.pwdata[7:0], req.pstrb[0]) & `TCP_CTRL_MASK;
        end
        `TCP_OFF_STATUS: begin
          zds_clr = req.pstrb[0] && req.pwdata[0];
        end
        `TCP_OFF_PRELOAD: begin
          for (int b = 0; b < 3; b++) begin
            next_k.preload[b*8 +: 8] = lane(k.preload[b*8 +: 8], req.pwdata[b*8 +: 8], req.pstrb[b]);
          end
        end
        `TCP_OFF_PC_DATA: begin
          next_k.pc_data = lane(k.pc_data, req.pwdata[7:0], req.pstrb[0]);
        end
        `TCP_OFF_PC_DIR: begin
          next_s.pc_dir = lane(s.pc_dir, req.pwdata[7:0], req.pstrb[0]);
        end
        `TCP_OFF_VECTOR: begin
          next_s.vector = lane(s.vector, req.pwdata[7:0], req.pstrb[0]);
        end
        default: begin
          next_s.vector = s.vector;
        end
      endcase
    end

    // timer core
    if (!run_now) begin
      next_s.run = TCP_HALT;
      next_s.psc = `TCP_PSC_TOP;
      next_s.zero_detect_flag = 1'b0;
      next_s.first = 1'b1;
      next_s.timer_output_pin_sq = 1'b1;
    end else begin
      next_s.run = TCP_RUN;
      case (clk_mode)
        TCP_CLK_SYS, TCP_CLK_GATED: begin
          psc_step = 1'b1;
        end
        TCP_CLK_TIN_PSC: begin
          psc_step = tin_rise;
        end
        TCP_CLK_TIN: begin
          tick = tin_rise;
        end
        default: begin
          tick = 1'b0;
        end
      endcase
      if (psc_step) begin
        tick = (s.psc == '0);
        next_s.psc = s.psc - 5'h01;
      end
      if (tick) begin
        if (s.first) begin
          next_k.cnt = k.preload;
          next_s.first = 1'b0;
        end else if (k.cnt == '0) begin
          next_k.cnt = s.ctrl[`TCP_BIT_ZDCTL] ? `TCP_CNT_ONES : k.preload;
        end else begin
          next_k.cnt = k.cnt - `TCP_CNT_ONE;
          zds_set = (k.cnt == `TCP_CNT_ONE);
        end
      end
      // set wins over a same-cycle clear
      next_s.zero_detect_flag = zds_set || (s.zero_detect_flag && !zds_clr);
      if (zds_set) begin
        next_s.timer_output_pin_sq = !s.timer_output_pin_sq;
      end
    end

    // read data captured in the setup cycle, answered in the first access cycle
    next_s.pready = setup;
    if (setup) begin
      next_s.prdata = '0;
      next_s.pslverr = 1'b0;
      if (!req.pwrite) begin
        case (req.paddr)
          `TCP_OFF_CTRL: next_s.prdata[7:0] = s.ctrl & `TCP_CTRL_MASK;
          `TCP_OFF_STATUS: next_s.prdata[0] = s.zero_detect_flag;
          `TCP_OFF_PRELOAD: next_s.prdata[CNT_W-1:0] = k.preload;
          `TCP_OFF_COUNT: next_s.prdata[CNT_W-1:0] = k.cnt;
          `TCP_OFF_PC_DATA: next_s.prdata[7:0] = pc_view(s.pin_f, k.pc_data, s.pc_dir);
          `TCP_OFF_PC_DIR: next_s.prdata[7:0] = s.pc_dir;
          `TCP_OFF_VECTOR: next_s.prdata[7:0] = s.vector;
          default: next_s.pslverr = 1'b1;
        endcase
      end else begin
        case (req.paddr)
          `TCP_OFF_CTRL, `TCP_OFF_STATUS, `TCP_OFF_PRELOAD, `TCP_OFF_COUNT,
          `TCP_OFF_PC_DATA, `TCP_OFF_PC_DIR, `TCP_OFF_VECTOR: next_s.pslverr = 1'b0;
          default: next_s.pslverr = 1'b1;
        endcase
      end
    end

    // pad drive from the updated state; latch shows only on port c outputs
    next_s.pins.out = next_k.pc_data;
    next_s.pins.oe_n = ~next_s.pc_dir;
    if (next_s.ctrl[`TCP_BIT_CLK_HI:`TCP_BIT_CLK_LO] != TCP_CLK_SYS) begin
      next_s.pins.oe_n[`TCP_LINE_TIN] = 1'b1;
    end
    case (tcp_pin_mode_t'(next_s.ctrl[`TCP_BIT_PIN_HI:`TCP_BIT_PIN_LO]))
      TCP_PIN_PORTC0, TCP_PIN_PORTC1: begin
        next_s.pins.oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] = ~next_s.pc_dir[`TCP_LINE_TIMER_OUTPUT_PIN];
      end
      TCP_PIN_SQ0, TCP_PIN_SQ1: begin
        next_s.pins.out[`TCP_LINE_TIMER_OUTPUT_PIN] = next_s.timer_output_pin_sq;
        next_s.pins.oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] = 1'b0;
      end
      TCP_PIN_VEC_DIS: begin
        next_s.pins.oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] = 1'b1;
        next_s.pins.oe_n[`TCP_LINE_TIMER_ACKNOWLEDGE_PIN] = 1'b1;
      end
      TCP_PIN_VEC_EN: begin
        next_s.pins.out[`TCP_LINE_TIMER_OUTPUT_PIN] = 1'b0;
        next_s.pins.oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] = ~next_s.zero_detect_flag;
        next_s.pins.oe_n[`TCP_LINE_TIMER_ACKNOWLEDGE_PIN] = 1'b1;
      end
      TCP_PIN_AUTO_DIS: begin
        next_s.pins.oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] = 1'b1;
      end
      TCP_PIN_AUTO_EN: begin
        next_s.pins.out[`TCP_LINE_TIMER_OUTPUT_PIN] = 1'b0;
        next_s.pins.oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] = ~next_s.zero_detect_flag;
      end
      default: begin
        next_s.pins.oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] = 1'b1;
      end
    endcase

    // vector answer only in vectored enabled mode, acknowledge line low
    next_s.ack_valid = (tcp_pin_mode_t'(next_s.ctrl[`TCP_BIT_PIN_HI:`TCP_BIT_PIN_LO]) == TCP_PIN_VEC_EN)
                       && !next_s.pin_f[`TCP_LINE_TIMER_ACKNOWLEDGE_PIN];
    next_s.ack_vector = next_s.ack_valid ? next_s.vector : 8'h00;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset-cleared state
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '{ctrl: `TCP_CTRL_RST, psc: `TCP_PSC_TOP, first: 1'b1, run: TCP_HALT, timer_output_pin_sq: 1'b1,
             pin_f: 8'hff, sync1: 8'hff, sync2: 8'hff, sync3: 8'hff, tin_prev: 1'b1,
             pc_dir: `TCP_DIR_RST, vector: `TCP_VEC_RST, pins: '{out: 8'h00, oe_n: 8'hff},
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  // counter, preload and port c latch keep their value through reset
  always_ff @(posedge i_clk) begin
    k <= next_k;
  end

  // outputs straight from flops
  assign o_pready = s.pready;
  assign o_prdata = s.prdata;
  assign o_pslverr = s.pslverr;
  assign o_pc_out = s.pins.out;
  assign o_pc_oe_n = s.pins.oe_n;
  assign o_ack_valid = s.ack_valid;
  assign o_ack_vector = s.ack_vector;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  chk_halt_prescaler: assert property (s.run == TCP_HALT |-> s.psc == `TCP_PSC_TOP && !s.zero_detect_flag)
    else $error("halt did not force prescaler and flag");
  chk_enable_halt: assert property (!s.ctrl[`TCP_BIT_ENABLE] |=> s.run == TCP_HALT)
    else $error("disabled timer still running");
  chk_ctrl_bit3: assert property (setup && !i_pwrite && i_paddr == `TCP_OFF_CTRL |=> !o_prdata[3])
    else $error("control bit 3 read as one");
  chk_wrap_ones: assert property (tick && !s.first && k.cnt == '0 && s.ctrl[`TCP_BIT_ZDCTL]
                                  |=> k.cnt == `TCP_CNT_ONES)
    else $error("wrap did not give all ones");
  chk_zero_reload: assert property (tick && !s.first && k.cnt == '0 && !s.ctrl[`TCP_BIT_ZDCTL]
                                    |=> k.cnt == $past(k.preload))
    else $error("no reload after zero");
  chk_zds_set: assert property (tick && !s.first && k.cnt == `TCP_CNT_ONE |=> s.zero_detect_flag && k.cnt == '0)
    else $error("flag not set on one to zero");
  chk_vec_request: assert property (pin_mode == TCP_PIN_VEC_EN && s.zero_detect_flag
                                    |-> !o_pc_oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] && !o_pc_out[`TCP_LINE_TIMER_OUTPUT_PIN])
    else $error("request line not low with flag set");
  chk_vec_disabled: assert property (pin_mode == TCP_PIN_VEC_DIS
                                     |-> o_pc_oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] && !o_ack_valid)
    else $error("disabled vectored mode drove request or answered");
  chk_square_out: assert property (s.ctrl[7:6] == 2'b01
                                   |-> !o_pc_oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] && o_pc_out[`TCP_LINE_TIMER_OUTPUT_PIN] == s.timer_output_pin_sq)
    else $error("square wave line mismatch");
  chk_portc_drive: assert property (s.ctrl[7:6] == 2'b00 && s.pc_dir[`TCP_LINE_TIMER_OUTPUT_PIN]
                                    |-> !o_pc_oe_n[`TCP_LINE_TIMER_OUTPUT_PIN] && o_pc_out[`TCP_LINE_TIMER_OUTPUT_PIN] == k.pc_data[3])
    else $error("port c line not driven from latch");
  chk_first_load: assert property (tick && s.first |=> k.cnt == $past(k.preload) && !s.first)
    else $error("first counter clock did not load preload");

  cov_zero_detect: cover property (zds_set);
  cov_reload: cover property (tick && !s.first && k.cnt == '0 && !s.ctrl[`TCP_BIT_ZDCTL]);
  cov_ack: cover property (o_ack_valid);

endmodule // tcp_timer
`default_nettype wire

// [test/tcp_far_side.sv]
`timescale 1ns/1ns
`default_nettype none
module tcp_far_side (
  // clock
  input wire logic i_clk,
  // pad drive of the block
  input wire tcp_pkg::tcp_pins_t i_pads,
  // far-side levels set by the bench
  input wire logic i_tin_tog,
  input wire logic i_tin_lvl,
  input wire logic i_ack_n,
  input wire logic [7:0] i_other,
  // resolved pad levels
  output logic [7:0] o_pc_pin
);
  import tcp_pkg::*;
  logic [2:0] div = 3'h0;
  logic tin_q = 1'b0;
  logic [7:0] far;
  // external timer input toggles every 8 clocks, under the clk/8 limit
  always_ff @(posedge i_clk) begin
    div <= div + 3'h1;
    if (div == 3'h7) begin
      tin_q <= ~tin_q;
    end
  end
  // acknowledge is active low on line 7, timer input on line 2
  assign far = {i_ack_n, i_other[6:3], i_tin_tog ? tin_q : i_tin_lvl, i_other[1:0]};
  // a driven pad shows the block's value, otherwise the far side's
  assign o_pc_pin = (i_pads.oe_n & far) | (~i_pads.oe_n & i_pads.out);
endmodule // tcp_far_side
`default_nettype wire

// [test/tcp_timer_bench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tcp_defines.svh"
module tcp_timer_bench;
  import tcp_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, ack_valid, err;
  logic [31:0] prdata;
  logic [7:0] pc_pin, pc_out, pc_oe_n, ack_vec;
  logic tog = 1'b0;
  logic tin_lvl = 1'b0;
  logic ack_n = 1'b1;
  logic [7:0] oth = 8'h00;
  logic [31:0] lfsr = 32'ha939;
  tcp_pins_t pads;
  int miscompares = 0;
  int checks = 0;
  assign pads = {pc_out, pc_oe_n};
  always #4 clk = ~clk;
  tcp_timer i_dut (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_pc_pin(pc_pin), .o_pc_out(pc_out), .o_pc_oe_n(pc_oe_n),
    .o_ack_valid(ack_valid), .o_ack_vector(ack_vec));
  tcp_far_side i_far (.i_clk(clk), .i_pads(pads), .i_tin_tog(tog), .i_tin_lvl(tin_lvl),
    .i_ack_n(ack_n), .i_other(oth), .o_pc_pin(pc_pin));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // port c read: latch on outputs, pad level on inputs
  function automatic logic [31:0] exp_pc(logic [7:0] dir, logic [7:0] dat, logic [7:0] far);
    return {24'h0, (dir & dat) | (~dir & far)};
  endfunction
  task automatic end_sim();
    if (miscompares == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic wait_flag();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      apb(1'b0, `TCP_OFF_STATUS, 32'h0, q);
      n++;
    end while (q !== 32'h1 && n < 1000);
    if (q !== 32'h1) begin
      miscompares++;
      end_sim();
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic [31:0] q, dir, dat;
    logic [2:0] m;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rdc(`TCP_OFF_CTRL, 32'h0);
    rdc(`TCP_OFF_STATUS, 32'h0);
    rdc(`TCP_OFF_PC_DIR, 32'h0);
    rdc(`TCP_OFF_VECTOR, 32'h0f);
    apb(1'b0, 8'h1c, 32'h0, q);
    chk(32'(err), 32'h1);
    wr(`TCP_OFF_CTRL, 32'hfe);
    rdc(`TCP_OFF_CTRL, 32'hf6);
    wr(`TCP_OFF_CTRL, 32'h20);
    // random port c traffic, pin mode 001, all lines in port c use
    for (int i = 0; i < 4; i++) begin
      dir = rnd();
      dat = rnd();
      q = rnd();
      oth <= q[7:0];
      tin_lvl <= q[2];
      ack_n <= q[7];
      wr(`TCP_OFF_PC_DIR, {24'h0, dir[7:0]});
      wr(`TCP_OFF_PC_DATA, {24'h0, dat[7:0]});
      repeat (8) @(posedge clk);
      rdc(`TCP_OFF_PC_DATA, exp_pc(dir[7:0], dat[7:0], q[7:0]));
      chk({24'h0, pc_oe_n}, {24'h0, ~dir[7:0]});
      chk({24'h0, pc_out & dir[7:0]}, {24'h0, dat[7:0] & dir[7:0]});
    end
    // second reset leaves the latch alone
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdc(`TCP_OFF_CTRL, 32'h0);
    wr(`TCP_OFF_PC_DIR, 32'hff);
    rdc(`TCP_OFF_PC_DATA, {24'h0, dat[7:0]});
    wr(`TCP_OFF_PC_DIR, 32'h0);
    // system clock path, reload then wrap
    wr(`TCP_OFF_PRELOAD, 32'h2);
    tin_lvl <= 1'b1;
    wr(`TCP_OFF_CTRL, 32'h01);
    wait_flag();
    rdc(`TCP_OFF_COUNT, 32'h0);
    repeat (34) @(posedge clk);
    rdc(`TCP_OFF_COUNT, 32'h2);
    wr(`TCP_OFF_STATUS, 32'h1);
    rdc(`TCP_OFF_STATUS, 32'h0);
    wr(`TCP_OFF_CTRL, 32'h11);
    wait_flag();
    repeat (34) @(posedge clk);
    rdc(`TCP_OFF_COUNT, 32'hffffff);
    wr(`TCP_OFF_CTRL, 32'h0);
    rdc(`TCP_OFF_STATUS, 32'h0);
    repeat (40) @(posedge clk);
    rdc(`TCP_OFF_COUNT, 32'hffffff);
    // gated, external prescaled and external direct clock paths
    for (int c = 1; c < 4; c++) begin
      tog <= (c != 1);
      tin_lvl <= (c != 1);
      wr(`TCP_OFF_CTRL, 32'h01 | (c << 1));
      if (c == 1) begin
        repeat (300) @(posedge clk);
        rdc(`TCP_OFF_STATUS, 32'h0);
        tin_lvl <= 1'b1;
      end
      wait_flag();
      wr(`TCP_OFF_CTRL, 32'h0);
    end
    // square wave: low after first zero detect, high again once halted
    tog <= 1'b0;
    ack_n <= 1'b0;
    wr(`TCP_OFF_CTRL, 32'h61);
    wait_flag();
    chk({30'h0, pc_oe_n[3], pc_out[3]}, 32'h0);
    wr(`TCP_OFF_CTRL, 32'h40);
    repeat (2) @(posedge clk);
    chk({30'h0, pc_oe_n[3], pc_out[3]}, 32'h1);
    // the four interrupt configurations
    for (int k = 4; k < 8; k++) begin
      m = k[2:0];
      wr(`TCP_OFF_CTRL, {24'h0, m, 5'b10001});
      wait_flag();
      chk(32'(pc_oe_n[3]), {31'h0, ~m[0]});
      chk(32'(ack_valid), 32'(m == 3'b101));
      chk({24'h0, ack_vec}, (m == 3'b101) ? 32'h0f : 32'h0);
      if (m[0]) begin
        chk(32'(pc_out[3]), 32'h0);
      end
      wr(`TCP_OFF_CTRL, 32'h0);
    end
    end_sim();
  end
endmodule // tcp_timer_bench
`default_nettype wire
